// ===== logic/exec_state_defines.svh
// constants for the execution-state bits of the combined status register
// assumes a 32-bit status word with the bit layout given below
`ifndef EXEC_STATE_DEFINES_SVH
`define EXEC_STATE_DEFINES_SVH

// --------------------------------------------------------------------------
// field positions
// --------------------------------------------------------------------------
`define ESB_Q_BIT          27
`define ESB_RC_HI_MSB      26
`define ESB_RC_HI_LSB      25
`define ESB_ISA_BIT        24
`define ESB_RSVD_HI_MSB    23
`define ESB_RSVD_HI_LSB    16
`define ESB_RC_LO_MSB      15
`define ESB_RC_LO_LSB      10
`define ESB_REG_MSB        15
`define ESB_REG_LSB        12
`define ESB_RSVD_LO_MSB    9
`define ESB_RSVD_LO_LSB    7

// --------------------------------------------------------------------------
// reset values
// --------------------------------------------------------------------------
`define ESB_STATUS_RESET   32'h0100_0000
`define ESB_FIELD_RESET    8'h00
`define ESB_ISA_RESET      1'b1
`define ESB_Q_RESET        1'b0

`endif

// ===== logic/exec_state_pkg.sv
// types shared by the execution-state status logic
// assumes the constants of exec_state_defines.svh
package exec_state_pkg;

   // --------------------------------------------------------------------------
   // views of the combined status register
   // --------------------------------------------------------------------------
   typedef enum logic [2:0] {
      VIEW_COMBINED,
      VIEW_IEPSR,
      VIEW_IAPSR,
      VIEW_EAPSR,
      VIEW_APSR,
      VIEW_EXEC,
      VIEW_IPSR
   } view_e;

   // what the split field currently holds
   typedef enum logic [1:0] {
      FM_IDLE,
      FM_RESUME,
      FM_COND
   } field_mode_e;

   // multi-register transfer events
   typedef struct packed {
      logic       interrupt;   // transfer suspended by an interrupt
      logic       done;        // transfer finished
      logic [3:0] next_reg;    // next register operand
   } xfer_evt_s;

   // conditional-block events
   typedef struct packed {
      logic       start;       // block-opening instruction executed
      logic       advance;     // one instruction of the block retired
      logic [7:0] value;       // condition and mask from the opener
   } cond_evt_s;

   // sources that load the instruction-set state bit
   typedef struct packed {
      logic       branch;      // indirect branch, link-exchange, pop to pc
      logic       vec_load;    // vector fetched on exception entry or reset
      logic       target_lsb;  // bit 0 of target or vector
   } isa_src_s;

endpackage

// ===== logic/exec_state_status_bits.sv
// execution-state bits of the combined status register
// assumes the core pipeline delivers one-cycle event pulses on core_clk_i
`include "exec_state_defines.svh"

module exec_state_status_bits (
   input  wire logic                      core_clk_i,
   input  wire logic                      resetn_i,
   input  wire logic                      clk_en_i,
   input  wire exec_state_pkg::xfer_evt_s xfer_i,
   input  wire exec_state_pkg::cond_evt_s cond_i,
   input  wire exec_state_pkg::isa_src_s  isa_src_i,
   input  wire logic                      exc_entry_i,
   input  wire logic                      exc_return_i,
   input  wire logic [31:0]               stacked_word_i,
   input  wire logic                      sat_set_i,
   input  wire logic                      exec_i,
   input  wire logic                      hard_fault_active_i,
   input  wire logic                      rd_en_i,
   input  wire logic                      wr_en_i,
   input  wire exec_state_pkg::view_e     view_i,
   input  wire logic                      privileged_i,
   input  wire logic [31:0]               wr_data_i,
   output logic [31:0]                    rd_data_o,
   output logic                           rd_valid_o,
   output logic [31:0]                    status_word_o,
   output logic                           resume_valid_o,
   output logic [3:0]                     resume_reg_o,
   output logic                           fault_o,
   output logic                           lockup_o
);
   import exec_state_pkg::*;

   // --------------------------------------------------------------------------
   // state
   // --------------------------------------------------------------------------
   logic [7:0]  field;        // {bits 15:10, bits 26:25}
   field_mode_e mode;
   logic        isa_bit;
   logic        q_flag;
   logic [7:0]  restore_field;
   logic        restore_resume;
   logic        q_write;
   logic        next_q;
   logic        exec_vis;

   // --------------------------------------------------------------------------
   // decode of the saved status word
   // --------------------------------------------------------------------------
   // resume state is told apart by zero bits 26:25 and 11:10 with a register
   // set; a live conditional block never has its mask low bits all zero
   assign restore_field = {
      stacked_word_i[`ESB_RC_LO_MSB:`ESB_RC_LO_LSB],
      stacked_word_i[`ESB_RC_HI_MSB:`ESB_RC_HI_LSB]};
   assign restore_resume = (restore_field[3:0] == 4'h0)
                         && (restore_field[7:4] != 4'h0);

   // --------------------------------------------------------------------------
   // split field: resume point or conditional block
   // --------------------------------------------------------------------------
   // no write port: software can never disturb it
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         field <= `ESB_FIELD_RESET;
         mode  <= FM_IDLE;
      end else if (clk_en_i) begin
         if (exc_return_i) begin
            field <= restore_field;
            mode  <= restore_resume ? FM_RESUME :
                     (restore_field == 8'h00) ? FM_IDLE : FM_COND;
         end else if (xfer_i.interrupt) begin
            field <= {xfer_i.next_reg, 4'h0};
            mode  <= FM_RESUME;
         end else if (exc_entry_i) begin
            field <= `ESB_FIELD_RESET;  // handler starts with a clean field
            mode  <= FM_IDLE;
         end else if (cond_i.start) begin
            field <= cond_i.value;
            mode  <= FM_COND;
         end else if (cond_i.advance && mode == FM_COND) begin
            // mask shifts once per instruction: at most four of them
            if (field[2:0] == 3'h0) begin
               field <= `ESB_FIELD_RESET;
               mode  <= FM_IDLE;
            end else begin
               field <= {field[7:5], field[3:0], 1'b0};
            end
         end else if (xfer_i.done && mode == FM_RESUME) begin
            field <= `ESB_FIELD_RESET;
            mode  <= FM_IDLE;
         end
      end
   end

   // --------------------------------------------------------------------------
   // resume hand-off to the transfer engine
   // --------------------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         resume_valid_o <= 1'b0;
         resume_reg_o   <= 4'h0;
      end else if (clk_en_i) begin
         resume_valid_o <= exc_return_i && restore_resume;
         if (exc_return_i && restore_resume) begin
            resume_reg_o <= restore_field[7:4];
         end
      end
   end

   // --------------------------------------------------------------------------
   // instruction-set state bit
   // --------------------------------------------------------------------------
   // return beats vector load beats branch when they coincide
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         isa_bit <= `ESB_ISA_RESET;
      end else if (clk_en_i) begin
         if (exc_return_i) begin
            isa_bit <= stacked_word_i[`ESB_ISA_BIT];
         end else if (isa_src_i.vec_load) begin
            isa_bit <= isa_src_i.target_lsb;
         end else if (isa_src_i.branch) begin
            isa_bit <= isa_src_i.target_lsb;
         end
      end
   end

   // --------------------------------------------------------------------------
   // fault and lockup on execution with the bit clear
   // --------------------------------------------------------------------------
   // a second fault inside the hard-fault handler cannot escalate: lock up
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         fault_o  <= 1'b0;
         lockup_o <= 1'b0;
      end else if (clk_en_i) begin
         fault_o <= exec_i && !isa_bit && !hard_fault_active_i;
         if (exec_i && !isa_bit && hard_fault_active_i) begin
            lockup_o <= 1'b1;
         end
      end
   end

   // --------------------------------------------------------------------------
   // saturation flag
   // --------------------------------------------------------------------------
   // application view writes are allowed unprivileged, combined, IAPSR and EAPSR writes need privilege, other views never write
   assign q_write = wr_en_i && (view_i == VIEW_APSR
                 || (privileged_i && (view_i == VIEW_COMBINED
                 || view_i == VIEW_IAPSR || view_i == VIEW_EAPSR)));
   always_comb begin
      next_q = q_flag;
      if (q_write) begin
         next_q = wr_data_i[`ESB_Q_BIT];
      end
      if (sat_set_i) begin
         next_q = 1'b1;                 // a set in the clear cycle survives
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         q_flag <= `ESB_Q_RESET;
      end else if (clk_en_i) begin
         q_flag <= next_q;
      end
   end

   // --------------------------------------------------------------------------
   // read path
   // --------------------------------------------------------------------------
   assign status_word_o = {4'h0, q_flag, field[1:0], isa_bit, 8'h00,
                           field[7:2], 10'h000};
   assign exec_vis = (view_i == VIEW_COMBINED && privileged_i)
                  || (view_i == VIEW_EXEC && privileged_i);

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rd_data_o  <= 32'h0000_0000;
         rd_valid_o <= 1'b0;
      end else if (clk_en_i) begin
         rd_valid_o <= rd_en_i;
         if (rd_en_i) begin
            rd_data_o <= 32'h0000_0000;
            if (exec_vis) begin
               rd_data_o[`ESB_RC_HI_MSB:`ESB_RC_HI_LSB] <= field[1:0];
               rd_data_o[`ESB_ISA_BIT] <= isa_bit;
               rd_data_o[`ESB_RC_LO_MSB:`ESB_RC_LO_LSB] <= field[7:2];
            end
            if (view_i == VIEW_APSR || (privileged_i
                && (view_i == VIEW_COMBINED || view_i == VIEW_IAPSR
                || view_i == VIEW_EAPSR))) begin
               rd_data_o[`ESB_Q_BIT] <= q_flag;
            end
         end
      end
   end

   // --------------------------------------------------------------------------
   // checks
   // --------------------------------------------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);

   logic started;  // low until the first edge after reset release
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         started <= 1'b0;
      end else begin
         started <= 1'b1;
      end
   end

   sequence s_ldm_irq;
      clk_en_i && xfer_i.interrupt && !exc_return_i;
   endsequence

   sequence s_restore_resume;
      clk_en_i && exc_return_i && restore_resume;
   endsequence

   sequence s_quiet_field;
      clk_en_i && !exc_return_i && !xfer_i.interrupt && !exc_entry_i
         && !cond_i.start && !cond_i.advance && !xfer_i.done;
   endsequence

   a_q_holds: assert property (
      (q_flag && !q_write) |=> q_flag)
      else $error("saturation flag cleared without a write");

   a_field_readonly: assert property (
      (s_quiet_field and wr_en_i) |=> $stable(field))
      else $error("split field changed on a write");

   a_resume_hi_zero: assert property (
      (mode == FM_RESUME) |-> status_word_o[26:25] == 2'b00)
      else $error("upper field bits set in resume state");

   a_resume_lo_zero: assert property (
      (mode == FM_RESUME) |-> status_word_o[11:10] == 2'b00)
      else $error("low field bits set in resume state");

   a_resume_capture: assert property (
      s_ldm_irq |=> mode == FM_RESUME
         && status_word_o[15:12] == $past(xfer_i.next_reg))
      else $error("next register not recorded");

   a_resume_restart: assert property (
      s_restore_resume |=> (resume_valid_o
         && resume_reg_o == $past(stacked_word_i[15:12]))
         ##1 (!resume_valid_o || !$past(clk_en_i)
         || ($past(exc_return_i) && $past(restore_resume))))
      else $error("resume register not handed back");

   a_cond_last: assert property (
      (s_quiet_field or (clk_en_i && cond_i.advance && !exc_return_i
         && !xfer_i.interrupt && !exc_entry_i && !cond_i.start))
      ##0 (mode == FM_COND && cond_i.advance && field[2:0] == 3'h0)
      |=> mode == FM_IDLE && field == 8'h00)
      else $error("conditional block outlived its last instruction");

   a_isa_steady: assert property (
      (!clk_en_i || (!exc_return_i && !isa_src_i.vec_load
         && !isa_src_i.branch))
      |=> $stable(isa_bit))
      else $error("state bit changed without a source");

   a_isa_branch: assert property (
      (clk_en_i && isa_src_i.branch && !exc_return_i
         && !isa_src_i.vec_load)
      |=> isa_bit == $past(isa_src_i.target_lsb))
      else $error("branch did not load the state bit");

   a_isa_return: assert property (
      (clk_en_i && exc_return_i) |=> isa_bit == $past(stacked_word_i[24]))
      else $error("return did not restore the state bit");

   a_isa_vector: assert property (
      (clk_en_i && isa_src_i.vec_load && !exc_return_i)
      |=> isa_bit == $past(isa_src_i.target_lsb))
      else $error("vector bit 0 not loaded");

   // a fault pulse may only stay up when another execution or a low enable followed
   a_fault_clear: assert property (
      (clk_en_i && exec_i && !isa_bit)
      |=> (fault_o || lockup_o) ##1 (lockup_o || !fault_o
         || $past(exec_i) || !$past(clk_en_i)))
      else $error("execution with state bit clear not trapped");

   a_reserved_zero: assert property (
      rd_valid_o |-> rd_data_o[23:16] == 8'h00 && rd_data_o[9:7] == 3'h0)
      else $error("reserved bits read nonzero");

   a_view_hides: assert property (
      (clk_en_i && rd_en_i && view_i != VIEW_COMBINED && view_i != VIEW_EXEC)
      |=> rd_data_o[26:24] == 3'h0 && rd_data_o[15:10] == 6'h00)
      else $error("exec bits leaked through another view");

   a_app_read_zero: assert property (
      (clk_en_i && rd_en_i && view_i == VIEW_EXEC && !privileged_i)
      |=> rd_data_o == 32'h0000_0000)
      else $error("unprivileged exec view read nonzero");

   a_reset_value: assert property (
      !started |-> status_word_o == `ESB_STATUS_RESET)
      else $error("status word wrong after reset");

endmodule // exec_state_status_bits

// ===== verification/exec_state_status_bits_tb_top.sv
// self-checking bench for the execution-state status bits
// assumes the design package and defines header are compiled first
module exec_state_status_bits_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import exec_state_pkg::*;

   // -----------------------------------------------------------------------
   // stimulus and observation signals
   // -----------------------------------------------------------------------
   logic        core_clk_i;
   logic        resetn_i;
   logic        clk_en;
   xfer_evt_s   xfer;
   cond_evt_s   cond;
   isa_src_s    isa_src;
   logic        exc_entry;
   logic        exc_return;
   logic [31:0] stacked_word;
   logic        sat_set;
   logic        exec;
   logic        hard_fault_active;
   logic        rd_en;
   logic        wr_en;
   view_e       view;
   logic        privileged;
   logic [31:0] wr_data;
   logic [31:0] rd_data;
   logic        rd_valid;
   logic [31:0] status_word;
   logic        resume_valid;
   logic [3:0]  resume_reg;
   logic        fault;
   logic        lockup;
   logic [31:0] d;
   int          miscompares;
   int          checks;

   exec_state_status_bits dut_u (
      .core_clk_i          (core_clk_i),
      .resetn_i            (resetn_i),
      .clk_en_i            (clk_en),
      .xfer_i              (xfer),
      .cond_i              (cond),
      .isa_src_i           (isa_src),
      .exc_entry_i         (exc_entry),
      .exc_return_i        (exc_return),
      .stacked_word_i      (stacked_word),
      .sat_set_i           (sat_set),
      .exec_i              (exec),
      .hard_fault_active_i (hard_fault_active),
      .rd_en_i             (rd_en),
      .wr_en_i             (wr_en),
      .view_i              (view),
      .privileged_i        (privileged),
      .wr_data_i           (wr_data),
      .rd_data_o           (rd_data),
      .rd_valid_o          (rd_valid),
      .status_word_o       (status_word),
      .resume_valid_o      (resume_valid),
      .resume_reg_o        (resume_reg),
      .fault_o             (fault),
      .lockup_o            (lockup)
   );

   // -----------------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------------
   // 125 MHz core clock
   initial begin
      core_clk_i = 1'b0;
      forever #4 core_clk_i = ~core_clk_i;
   end

   task automatic finish_test();
      $display("miscompares=%0d checks=%0d", miscompares, checks);
      if (miscompares == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // case equality so an unknown never counts as a match
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string msg);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg,
                  got, exp);
      end
   endtask

   // inputs always move 1 ns after the rising edge
   task automatic step();
      @(posedge core_clk_i);
      #1;
   endtask

   // one-cycle event pulse: every raised pulse input is dropped after one edge; data inputs and hard_fault_active are kept
   task automatic fire();
      step();
      xfer.interrupt = 1'b0;
      xfer.done      = 1'b0;
      cond.start     = 1'b0;
      cond.advance   = 1'b0;
      isa_src.branch   = 1'b0;
      isa_src.vec_load = 1'b0;
      exc_entry      = 1'b0;
      exc_return     = 1'b0;
      sat_set        = 1'b0;
      exec           = 1'b0;
   endtask

   // read via a view; answer stands in the cycle after the request
   task automatic reg_read(input view_e v, input logic priv,
                           output logic [31:0] data);
      view       = v;
      privileged = priv;
      rd_en      = 1'b1;
      step();
      rd_en      = 1'b0;
      chk({31'd0, rd_valid}, 32'd1, "read answer");
      data = rd_data;
      // let an edge pass so a following request never re-raises at once
      step();
   endtask

   task automatic reg_write(input view_e v, input logic priv,
                            input logic [31:0] data);
      view       = v;
      privileged = priv;
      wr_data    = data;
      wr_en      = 1'b1;
      step();
      wr_en      = 1'b0;
      step();
   endtask

   // -----------------------------------------------------------------------
   // watchdog: the whole sequence needs well under a thousand cycles
   // -----------------------------------------------------------------------
   initial begin
      #100us;
      miscompares++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      finish_test();
   end

   // -----------------------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------------------
   initial begin
      miscompares = 0;
      checks = 0;
      resetn_i = 1'b0;
      clk_en = 1'b1;
      xfer = '0;
      cond = '0;
      isa_src = '0;
      exc_entry = 1'b0;
      exc_return = 1'b0;
      stacked_word = 32'h0000_0000;
      sat_set = 1'b0;
      exec = 1'b0;
      hard_fault_active = 1'b0;
      rd_en = 1'b0;
      wr_en = 1'b0;
      view = VIEW_COMBINED;
      privileged = 1'b1;
      wr_data = 32'h0000_0000;
      repeat (4) @(posedge core_clk_i);
      #1;
      chk(status_word, 32'h0100_0000, "reset word");
      resetn_i = 1'b1;
      reg_read(VIEW_COMBINED, 1'b1, d);
      chk(d, 32'h0100_0000, "combined after reset");
      reg_read(VIEW_EXEC, 1'b0, d);
      chk(d, 32'h0000_0000, "unpriv exec view");
      // saturation flag: set by hardware, cleared only by a write
      sat_set = 1'b1;
      fire();
      repeat (3) step();
      chk({31'd0, status_word[27]}, 32'd1, "q holds");
      reg_read(VIEW_APSR, 1'b0, d);
      chk(d, 32'h0800_0000, "flag view");
      reg_write(VIEW_COMBINED, 1'b1, 32'hFFFF_FFFF);
      chk(status_word, 32'h0900_0000, "read-only bits");
      reg_write(VIEW_APSR, 1'b0, 32'h0000_0000);
      chk(status_word, 32'h0100_0000, "q cleared");
      // with the flag clear, an ignored exec-view write is visible
      reg_write(VIEW_EXEC, 1'b0, 32'hFFFF_FFFF);
      chk(status_word, 32'h0100_0000, "exec view write");
      // interrupted multi-register transfer
      xfer.interrupt = 1'b1;
      xfer.next_reg = 4'h5;
      fire();
      chk(status_word, 32'h0100_5000, "resume state");
      reg_read(VIEW_EXEC, 1'b1, d);
      chk(d, 32'h0100_5000, "priv exec view");
      reg_read(VIEW_IAPSR, 1'b1, d);
      chk(d, 32'h0000_0000, "flag and number view hides");
      reg_read(VIEW_COMBINED, 1'b0, d);
      chk(d, 32'h0000_0000, "unpriv combined");
      xfer.done = 1'b1;
      fire();
      chk(status_word, 32'h0100_0000, "transfer done");
      step();
      // return with a saved word: reserved set, state bit clear, reg 7
      stacked_word = 32'h00FF_7000;
      exc_return = 1'b1;
      fire();
      chk({31'd0, resume_valid}, 32'd1, "resume pulse");
      chk({28'd0, resume_reg}, 32'd7, "resume reg");
      chk(status_word, 32'h0000_7000, "restored word");
      step();
      chk({31'd0, resume_valid}, 32'd0, "resume pulse ends");
      xfer.done = 1'b1;
      exec = 1'b1;
      fire();
      chk({31'd0, fault}, 32'd1, "fault on clear bit");
      step();
      // vector and branch loads of the state bit
      isa_src.vec_load = 1'b1;
      isa_src.target_lsb = 1'b1;
      fire();
      chk({31'd0, status_word[24]}, 32'd1, "vector lsb");
      step();
      isa_src.branch = 1'b1;
      isa_src.target_lsb = 1'b0;
      fire();
      chk({31'd0, status_word[24]}, 32'd0, "branch lsb");
      step();
      isa_src.vec_load = 1'b1;
      isa_src.target_lsb = 1'b1;
      fire();
      step();
      // four-instruction conditional block
      cond.start = 1'b1;
      cond.value = 8'h0F;
      fire();
      chk(status_word, 32'h0700_0C00, "block opened");
      step();
      // advance held over three edges retires three instructions
      cond.advance = 1'b1;
      repeat (3) step();
      chk({31'd0, |{status_word[26:25], status_word[15:10]}}, 32'd1,
          "block live");
      fire();
      chk(status_word, 32'h0100_0000, "block ended");
      step();
      // a low enable freezes all state: the opener must not be taken
      clk_en = 1'b0;
      cond.start = 1'b1;
      cond.value = 8'h0F;
      fire();
      chk(status_word, 32'h0100_0000, "frozen by enable");
      clk_en = 1'b1;
      step();
      // clear state bit while the hard-fault handler runs
      isa_src.branch = 1'b1;
      isa_src.target_lsb = 1'b0;
      fire();
      step();
      hard_fault_active = 1'b1;
      exec = 1'b1;
      fire();
      chk({31'd0, lockup}, 32'd1, "lockup");
      hard_fault_active = 1'b0;
      // second reset in mid-run
      resetn_i = 1'b0;
      step();
      chk(status_word, 32'h0100_0000, "second reset");
      chk({31'd0, lockup}, 32'd0, "lockup cleared");
      resetn_i = 1'b1;
      step();
      finish_test();
   end

endmodule // exec_state_status_bits_tb_top
